// *** rtl/ebz_defines.svh ***
// register offsets, field positions, reset values and timing counts of the zone timing block
`ifndef EBZ_DEFINES_SVH
`define EBZ_DEFINES_SVH

// byte addresses on the register bus
`define EBZ_OFS_ZONE_TIMING 4'h0
`define EBZ_OFS_ZONE_STATUS 4'h4

// zone_access_timing field positions
`define EBZ_POS_DOUBLE 22
`define EBZ_POS_WIDTH_HI 17
`define EBZ_POS_WIDTH_LO 16
`define EBZ_POS_RDY_MODE 15
`define EBZ_POS_RDY_EN 14
`define EBZ_POS_RD_LEAD_HI 13
`define EBZ_POS_RD_LEAD_LO 12
`define EBZ_POS_RD_ACT_HI 11
`define EBZ_POS_RD_ACT_LO 9
`define EBZ_POS_WR_LEAD_HI 6
`define EBZ_POS_WR_LEAD_LO 5
`define EBZ_POS_WR_ACT_HI 4
`define EBZ_POS_WR_ACT_LO 2

// writable bits and value after reset
`define EBZ_TIMING_MASK 32'h0043ffff
`define EBZ_TIMING_RESET 32'h0043ffff

// bus width codes
`define EBZ_WIDTH_32 2'h1
`define EBZ_WIDTH_16 2'h3

// timing clock divider and ready synchroniser depth
`define EBZ_TIM_DIV 4'h1
`define EBZ_SYNC_STAGES 2

`endif

// *** rtl/ebz_pkg.sv ***
// types shared by the zone timing block
package ebz_pkg;

	// access sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_LEAD = 3'h2,
		ST_ACTIVE = 3'h4
	} ebz_state_e;

	// wait-state count in timing clock ticks
	typedef logic [3:0] ebz_count_t;

endpackage

// *** rtl/ebz_ready_sync.sv ***
// multi-stage synchroniser for the external wait-ready input
`timescale 1ns/1ps

module ebz_ready_sync #(
	parameter int STAGES = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// raw and synchronised level
	input wire logic din,
	output logic dout
);

	logic [STAGES-1:0] chain;
	logic [STAGES-1:0] next_chain;

	// shift in; only the last stage is read outside
	always_comb begin
		next_chain = {chain[STAGES-2:0], din};
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			chain <= '0;
		end else begin
			chain <= next_chain;
		end
	end

	assign dout = chain[STAGES-1];

endmodule

// *** rtl/ebz_zone_timing.sv ***
// zone timing register and access sequencer of the external parallel bus
`timescale 1ns/1ps
`include "ebz_defines.svh"

// Contract
// - width code 01 uses 32 lines, shared pin is upper write strobe
// - width code 11 uses 16 lines, shared pin is address bit zero; reset value
// - ready mode 0 samples wait-ready input directly as synchronous
// - ready mode 1 samples wait-ready asynchronously; reset default
// - ready mode bit is ignored while ready enable is 0
// - ready enable 0 ignores wait-ready; access timed purely by counts
// - ready enable 1 stretches active phase while device holds not-ready
// - lead codes 01,10,11 give 1,2,3 cycles, doubled 2,4,6; reset 11
// - doubling bit doubles the read and write lead and active wait states
// - active phase is one base cycle plus the programmed count
// - active code n gives n wait cycles, 2n doubled; reset 111
module ebz_zone_timing #(
	parameter logic [3:0] TIM_DIV = `EBZ_TIM_DIV,
	parameter int SYNC_STAGES = `EBZ_SYNC_STAGES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// avalon-mm register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// core access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic acc_addr0,
	input wire logic acc_upper,
	output logic acc_done,
	// external bus pins
	input wire logic wait_ready_in,
	output logic zone_cs_b,
	output logic rd_strobe_b,
	output logic lower_write_strobe_b,
	output logic addr0_or_upper_write_strobe,
	output logic data_bus_32
);

	// lead length in ticks for a 2-bit code
	function automatic ebz_pkg::ebz_count_t lead_len(input logic [1:0] code, input logic dbl);
		lead_len = dbl ? {1'b0, code, 1'b0} : {2'h0, code};
	endfunction

	// active length: one base tick plus the count, count doubled when dbl is set
	function automatic ebz_pkg::ebz_count_t act_len(input logic [2:0] code, input logic dbl);
		act_len = dbl ? {code, 1'b1} : ({1'b0, code} + 4'h1);
	endfunction

	// timing clock enable from the system clock
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic tick;

	always_comb begin
		tick = (div_cnt == TIM_DIV - 4'h1);
		next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// register file and bus answer
	logic [31:0] timing_reg;
	logic [31:0] next_timing_reg;
	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	ebz_pkg::ebz_state_e state;
	ebz_pkg::ebz_state_e next_state;

	// one wait cycle per access; readdata is captured in it
	always_comb begin
		next_timing_reg = timing_reg;
		next_ack = (avs_read | avs_write) & ~ack;
		next_readdata = avs_readdata;
		if ((avs_read | avs_write) && !ack) begin
			next_readdata = 32'h0;
			if (avs_read && avs_address == `EBZ_OFS_ZONE_TIMING) begin
				next_readdata = timing_reg;
			end
			if (avs_read && avs_address == `EBZ_OFS_ZONE_STATUS) begin
				next_readdata = {29'h0, state};
			end
		end
		// reserved width codes stored as written
		// a write lands only at the edge where waitrequest is low
		if (avs_write && ack && avs_address == `EBZ_OFS_ZONE_TIMING) begin
			for (int b = 0; b < 4; b++) begin
				if (avs_byteenable[b]) begin
					next_timing_reg[b*8 +: 8] = avs_writedata[b*8 +: 8];
				end
			end
			next_timing_reg = next_timing_reg & `EBZ_TIMING_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			timing_reg <= `EBZ_TIMING_RESET;
			ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			timing_reg <= next_timing_reg;
			ack <= next_ack;
			avs_readdata <= next_readdata;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	// ready input paths
	logic ready_synced;

	ebz_ready_sync #(
		.STAGES(SYNC_STAGES)
	) u_ready_sync (
		.clock(clock),
		.rst_b(rst_b),
		.din(wait_ready_in),
		.dout(ready_synced)
	);

	// access sequencer; settings are snapshot at start so mid-access writes wait
	logic [31:0] snap;
	logic [31:0] next_snap;
	logic snap_write;
	logic next_snap_write;
	logic snap_addr0;
	logic next_snap_addr0;
	logic snap_upper;
	logic next_snap_upper;
	ebz_pkg::ebz_count_t cnt;
	ebz_pkg::ebz_count_t next_cnt;
	logic next_done;
	logic dbl;
	logic ready_ok;
	logic ready_hold;
	ebz_pkg::ebz_count_t cur_act;

	always_comb begin
		dbl = snap[`EBZ_POS_DOUBLE];
		ready_ok = snap[`EBZ_POS_RDY_MODE] ? ready_synced : wait_ready_in;
		// mode bit ignored when ready is off
		ready_hold = snap[`EBZ_POS_RDY_EN] & ~ready_ok;
		cur_act = snap_write ?
			act_len(snap[`EBZ_POS_WR_ACT_HI:`EBZ_POS_WR_ACT_LO], dbl) :
			act_len(snap[`EBZ_POS_RD_ACT_HI:`EBZ_POS_RD_ACT_LO], dbl);
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_snap = snap;
		next_snap_write = snap_write;
		next_snap_addr0 = snap_addr0;
		next_snap_upper = snap_upper;
		next_done = 1'b0;
		unique case (state)
			ebz_pkg::ST_IDLE: begin
				if (acc_req) begin
					next_snap = timing_reg;
					next_snap_write = acc_write;
					next_snap_addr0 = acc_addr0;
					next_snap_upper = acc_upper;
					next_cnt = acc_write ?
						lead_len(timing_reg[`EBZ_POS_WR_LEAD_HI:`EBZ_POS_WR_LEAD_LO],
							timing_reg[`EBZ_POS_DOUBLE]) :
						lead_len(timing_reg[`EBZ_POS_RD_LEAD_HI:`EBZ_POS_RD_LEAD_LO],
							timing_reg[`EBZ_POS_DOUBLE]);
					next_state = ebz_pkg::ST_LEAD;
				end
			end
			ebz_pkg::ST_LEAD: begin
				// invalid lead code 00 skips straight to active
				if (cnt == 4'h0 || (tick && cnt == 4'h1)) begin
					next_cnt = cur_act;
					next_state = ebz_pkg::ST_ACTIVE;
				end else if (tick) begin
					next_cnt = cnt - 4'h1;
				end
			end
			ebz_pkg::ST_ACTIVE: begin
				if (tick && cnt == 4'h1) begin
					if (!ready_hold) begin
						next_done = 1'b1;
						next_state = ebz_pkg::ST_IDLE;
					end
				end else if (tick) begin
					next_cnt = cnt - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= ebz_pkg::ST_IDLE;
			cnt <= 4'h0;
			snap <= `EBZ_TIMING_RESET;
			snap_write <= 1'b0;
			snap_addr0 <= 1'b0;
			snap_upper <= 1'b0;
			acc_done <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			snap <= next_snap;
			snap_write <= next_snap_write;
			snap_addr0 <= next_snap_addr0;
			snap_upper <= next_snap_upper;
			acc_done <= next_done;
		end
	end

	// pin drive; strobes only in the active phase
	logic w32;
	logic in_active;

	always_comb begin
		w32 = snap[`EBZ_POS_WIDTH_HI:`EBZ_POS_WIDTH_LO] == `EBZ_WIDTH_32;
		in_active = state == ebz_pkg::ST_ACTIVE;
		zone_cs_b = state == ebz_pkg::ST_IDLE;
		rd_strobe_b = ~(in_active & ~snap_write);
		lower_write_strobe_b = ~(in_active & snap_write); // both halves, both widths
		data_bus_32 = w32;
		// shared pin as upper write strobe
		// shared pin as address bit zero
		addr0_or_upper_write_strobe = w32 ? ~(in_active & snap_write & snap_upper) : snap_addr0;
	end

	// helper: ticks spent in the current phase, saturating
	logic [4:0] ph_ticks;
	always_ff @(posedge clock) begin
		if (!rst_b || state != next_state) begin
			ph_ticks <= 5'h0;
		end else if (tick && ph_ticks != 5'h1f) begin
			ph_ticks <= ph_ticks + 5'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_upper_strobe_low: assert property (
		(in_active && w32 && snap_write && snap_upper) |-> !addr0_or_upper_write_strobe)
		else $error("upper write strobe not driven low");
	a_addr0_follows: assert property (
		(!w32 && state != ebz_pkg::ST_IDLE) |-> addr0_or_upper_write_strobe == snap_addr0)
		else $error("shared pin does not carry address bit zero");
	a_reset_value: assert property (
		$past(!rst_b) |-> (timing_reg == `EBZ_TIMING_RESET && !data_bus_32))
		else $error("timing register reset value wrong");
	a_lead_ticks: assert property (
		(state == ebz_pkg::ST_LEAD && tick && next_state == ebz_pkg::ST_ACTIVE && !snap_write)
		|-> ph_ticks + 5'h1 == {1'b0, lead_len(snap[13:12], dbl)})
		else $error("read lead length wrong");
	a_active_fixed: assert property (
		(in_active && next_state == ebz_pkg::ST_IDLE && !snap[`EBZ_POS_RDY_EN])
		|-> ph_ticks + 5'h1 == {1'b0, cur_act})
		else $error("active length wrong with ready off");
	a_active_min: assert property (
		(in_active && next_state == ebz_pkg::ST_IDLE) |-> ph_ticks + 5'h1 >= {1'b0, cur_act})
		else $error("active phase shorter than programmed");
	a_ready_stretch: assert property (
		(in_active && tick && cnt == 4'h1 && snap[14] && !ready_ok) |=> in_active)
		else $error("active phase not stretched");
	a_sync_raw: assert property (
		(in_active && tick && cnt == 4'h1 && snap[14] && !snap[15] && wait_ready_in)
		|=> !in_active)
		else $error("sync ready not taken directly");
	a_async_synced: assert property (
		(in_active && tick && cnt == 4'h1 && snap[14] && snap[15] && !ready_synced)
		|=> in_active)
		else $error("async ready bypassed synchroniser");
	a_mode_ignored: assert property (
		(in_active && tick && cnt == 4'h1 && !snap[14]) |=> !in_active && acc_done)
		else $error("ready considered while disabled");
	a_bus_answer: assert property (
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus answer late");

	c_upper_write: cover property (in_active && w32 && snap_write && snap_upper);
	c_stretched: cover property (in_active && tick && cnt == 4'h1 && ready_hold);
	c_doubled_read: cover property (acc_done && dbl && !snap_write);
	c_status_read: cover property (avs_read && avs_address == `EBZ_OFS_ZONE_STATUS);

endmodule

// *** tb/ebz_far_device.sv ***
// external zone device model that answers with a programmable not-ready stall
`timescale 1ns/1ps

module ebz_far_device (
	// clock and select from the zone logic
	input wire logic clock,
	input wire logic zone_cs_b,
	// stall length in cycles after select
	input wire logic [7:0] stall,
	// ready back to the zone logic
	output logic wait_ready_in
);
	logic [7:0] cnt;

	initial begin
		cnt = 8'h00;
		wait_ready_in = 1'b0;
	end

	// not-ready hold
	// deselected pin is undriven, so it toggles rather than keep a stale level
	always @(posedge clock) begin
		if (zone_cs_b) begin
			cnt <= 8'h00;
			wait_ready_in <= ~wait_ready_in;
		end else begin
			cnt <= cnt + 8'h01;
			wait_ready_in <= (cnt >= stall);
		end
	end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the zone timing block
`timescale 1ns/1ps
`include "ebz_defines.svh"

module tb;
	logic clock, rst_b, avs_read, avs_write, avs_waitrequest, acc_req, acc_write;
	logic acc_addr0, acc_upper, acc_done, wait_ready_in, zone_cs_b, rd_strobe_b;
	logic lower_write_strobe_b, addr0_or_upper_write_strobe, data_bus_32, w, a0, up;
	logic [3:0] avs_address, avs_byteenable, be;
	logic [31:0] avs_writedata, avs_readdata, rd, model, seed, wv;
	logic [7:0] stall;
	int failures, compares, n, cs_lo, st_lo, sh_lo, ln, an;

	ebz_zone_timing i_ebz_zone_timing (.clock, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .acc_req,
		.acc_write, .acc_addr0, .acc_upper, .acc_done, .wait_ready_in, .zone_cs_b,
		.rd_strobe_b, .lower_write_strobe_b, .addr0_or_upper_write_strobe, .data_bus_32);
	ebz_far_device i_ebz_far_device (.clock, .zone_cs_b, .stall, .wait_ready_in);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// expected lead and active lengths in ticks
	function automatic int lead_len(input logic [1:0] c, input logic d);
		return (c == 2'h0) ? 1 : c * (d ? 2 : 1);
	endfunction
	function automatic int act_len(input logic [2:0] c, input logic d);
		return 1 + c * (d ? 2 : 1);
	endfunction
	// byte-lane merge, unwritable bits read back as zero
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] b);
		for (int i = 0; i < 4; i++) if (b[i]) o[8*i +: 8] = v[8*i +: 8];
		return o & `EBZ_TIMING_MASK;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// avalon-mm cycle: held until waitrequest is sampled low, idle edge after
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= b;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clock);
		// no wait count assumed; only the watchdog ends a hang
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clock);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask

	// one core access, counting low cycles of select, strobe and shared pin
	task automatic access(input logic wt, input logic ad, input logic hi);
		acc_req <= 1'b1;
		acc_write <= wt;
		acc_addr0 <= ad;
		acc_upper <= hi;
		@(posedge clock);
		acc_req <= 1'b0;
		n = 0;
		cs_lo = 0;
		st_lo = 0;
		sh_lo = 0;
		do begin
			@(posedge clock);
			n++;
			cs_lo += (zone_cs_b === 1'b0);
			st_lo += ((wt ? lower_write_strobe_b : rd_strobe_b) === 1'b0);
			sh_lo += (addr0_or_upper_write_strobe === 1'b0);
		end while (acc_done !== 1'b1 && n < 300);
		@(posedge clock);
		chk(32'(acc_done), 32'h0);
	endtask

	initial begin
		#(8 * 30000);
		failures++;
		results();
	end

	initial begin
		{rst_b, avs_read, avs_write, acc_req, acc_write, acc_addr0, acc_upper} = 7'h0;
		avs_address = 4'h0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		stall = 8'h00;
		seed = 32'h6ffe;
		failures = 0;
		compares = 0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		// reset values, read-only status, unmapped place
		bus(1'b0, `EBZ_OFS_ZONE_TIMING, 32'h0, 4'hf);
		chk(rd, `EBZ_TIMING_RESET);
		chk(32'(data_bus_32), 32'h0);
		bus(1'b1, `EBZ_OFS_ZONE_STATUS, 32'hffffffff, 4'hf);
		bus(1'b0, `EBZ_OFS_ZONE_STATUS, 32'h0, 4'hf);
		chk(rd, 32'h1);
		bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
		bus(1'b0, 4'h8, 32'h0, 4'hf);
		chk(rd, 32'h0);
		// reset timing: 6 lead ticks, 1 + 14 active ticks
		access(1'b0, 1'b0, 1'b0);
		chk(n, 32'h16);
		chk(cs_lo, 32'h15);
		chk(st_lo, 32'h0f);
		model = `EBZ_TIMING_RESET;
		// random timings, widths and lanes with ready ignored
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			wv = seed;
			seed = lfsr(seed);
			wv[16] = 1'b1;
			wv[14] = 1'b0;
			if (wv[13:12] == 2'h0) wv[13] = 1'b1;
			if (wv[6:5] == 2'h0) wv[6] = 1'b1;
			be = seed[3:0] | 4'h2;
			{w, a0, up} = seed[6:4];
			bus(1'b1, `EBZ_OFS_ZONE_TIMING, wv, be);
			model = merge(model, wv, be);
			bus(1'b0, `EBZ_OFS_ZONE_TIMING, 32'h0, 4'hf);
			chk(rd, model);
			access(w, a0, up);
			ln = lead_len(w ? model[6:5] : model[13:12], model[22]);
			an = act_len(w ? model[4:2] : model[11:9], model[22]);
			chk(n, ln + an + 1);
			chk(st_lo, an);
			chk(32'(data_bus_32), 32'(model[17:16] == 2'h1));
			if (model[17:16] == 2'h1) chk(sh_lo, (w && up) ? an : 0);
			else chk(sh_lo, a0 ? 0 : ln + an + 1);
		end
		// stalled device: ready ignored, synchronous, asynchronous
		stall <= 8'h0a;
		for (int m = 0; m < 4; m++) begin
			wv = {9'h0, 1'b0, 4'h0, 2'h3, m[0], m[1], 2'h3, 3'h2, 9'h1ff};
			bus(1'b1, `EBZ_OFS_ZONE_TIMING, wv, 4'hf);
			access(1'b0, 1'b0, 1'b0);
			chk(n, m[1] ? (m[0] ? 15 : 13) : 7);
		end
		results();
	end
endmodule
